// ==== logic/cdv_map.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the core DVS block
// Assumes: 8-bit registers on the internal register port of the serial engine
// Notes:   Definitions only
`ifndef CDV_MAP_SVH
`define CDV_MAP_SVH

// Register offsets
`define CDV_OFS_MODE        8'h04
`define CDV_OFS_CTRL2       8'h05
`define CDV_OFS_CORE        8'h06
`define CDV_OFS_SLEW        8'h07
`define CDV_OFS_LDO         8'h08

// Field positions
`define CDV_BIT_GO          7
`define CDV_BIT_PINSEL      6
`define CDV_BIT_RIPPLE      3
`define CDV_BIT_MEM         2
`define CDV_BIT_SYS         1
`define CDV_BIT_CORE        0
`define CDV_LDOB_LSB        4
`define CDV_LDOA_LSB        0

// Reset values
`define CDV_RST_MODE        4'h0
`define CDV_RST_CTRL2       8'h40
`define CDV_RST_CORE_LO     5'h14
`define CDV_RST_CORE_HI     5'h1e
`define CDV_RST_SLEW        3'h6
`define CDV_RST_LDO         8'h23
`define CDV_RST_MV_LO       11'd1300

// Code values
`define CDV_SLEW_IMMEDIATE  3'h7
`define CDV_CODE_TOP        5'h1f
`define CDV_VBASE_MV        11'd800
`define CDV_VSTEP_MV        11'd25
`define CDV_VTOP_MV         11'd1600

// Timing: one 25 mV step at the slowest rate of 0.15 mV/us (150 uV/us)
`define CDV_STEP_UV         25000
`define CDV_SLOWEST_UV_US   150
`define CDV_CLK_MHZ         20
`define CDV_SLOWEST_STEP_CYCLES ((`CDV_STEP_UV * `CDV_CLK_MHZ) / `CDV_SLOWEST_UV_US)

`endif

// ==== logic/cdv_pkg.sv ====
// Purpose: Types shared by the core DVS block and its surroundings
// Assumes: cdv_map.svh holds all numbers
// Notes:   Types only
package cdv_pkg;

	// One access from the serial protocol engine
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cdv_reg_req_t;

	// Converter mode controls toward the analog side; ripple select is shared, the rest per converter
	typedef struct packed {
		logic       low_ripple;
		logic [2:0] forced_fixed_frequency;
		logic [2:0] discharge_on;
	} cdv_mode_t;

	typedef enum logic [0:0] {
		DVS_IDLE,
		DVS_RAMP
	} cdv_dvs_state_t;

endpackage

// ==== logic/cdv_step_timer.sv ====
// Purpose: Paces the core code ramp, one tick per 25 mV step interval
// Assumes: slew codes 0..6 halve the interval each step
// Notes:   Tick is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
`include "cdv_map.svh"

module cdv_step_timer #(
	parameter int unsigned SLOWEST_STEP_CYCLES = `CDV_SLOWEST_STEP_CYCLES,
	parameter int unsigned CNT_W               = 12
) (
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic             run,
	input  wire logic [2:0]       slew_code,
	output logic                  tick
);
	// Fastest rate must still give at least one cycle per step
	if ((SLOWEST_STEP_CYCLES >> 6) < 1 || SLOWEST_STEP_CYCLES >= (1 << CNT_W)) begin : g_chk
		$error("cdv_step_timer: SLOWEST_STEP_CYCLES does not fit the counter");
	end

	logic [CNT_W-1:0] count;
	wire  [CNT_W-1:0] interval  = CNT_W'(SLOWEST_STEP_CYCLES >> slew_code);
	wire  [CNT_W-1:0] reload    = interval - CNT_W'(1);
	wire              at_zero   = (count == '0);

	// Reload while stopped so a new ramp waits a full interval
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (!run) begin
			count <= reload;
			tick  <= 1'b0;
		end else begin
			count <= at_zero ? reload : count - CNT_W'(1);
			tick  <= at_zero;
		end
	end

endmodule

// ==== logic/cdv_core_ctrl.sv ====
// Purpose: Converter mode registers, core voltage code with slew ramp, regulator codes
// Assumes: Register port driven by the serial engine in sys_clk domain; inputs synchronous
// Notes:   Lockout and reset events load defaults synchronously while they are asserted
`timescale 1ns/1ps
`include "cdv_map.svh"

// Functional notes
// - Ripple bit 0 picks efficient light-load mode, 1 picks low-ripple mode.
// - Forced-PWM bits 2,1,0 hold memory, system, core converters in PWM.
// - Writing go 1 starts ramping the core code to the register target.
// - Go clears when stepped code equals target, and on undervoltage lockout.
// - Pin-select 1 uses the pin default 1.3 or 1.55 V, else register code.
// - Discharge bits actively discharge a converter output while it is disabled.
// - Second control register loads 40h on undervoltage lockout.
// - Core code default is 14h with pin low, 1Eh with pin high; upper bits zero.
// - Core code returns to default on lockout, both off, warm reset, power-on, backup low.
// - Slew code 0..6 doubles from 0.15 to 9.6 mV/us; 7 is immediate.
// - Slew register loads 06h on lockout; only three low bits exist.
// - Regulator register holds regulator b code in 6:4 and regulator a in 2:0.
// - Regulator register loads 23h on undervoltage lockout.
// - Core power-good flag reads zero while core is disabled or ramping.
module cdv_core_ctrl #(
	parameter int unsigned SLOWEST_STEP_CYCLES = `CDV_SLOWEST_STEP_CYCLES
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rstn,
	input  wire cdv_pkg::cdv_reg_req_t reg_req,
	output logic [7:0]                reg_rdata,
	input  wire logic                 undervoltage_lockout,
	input  wire logic                 warm_reset_input_n,
	input  wire logic                 power_on_reset_active,
	input  wire logic                 backup_rail_low,
	input  wire logic [2:0]           conv_enabled,
	input  wire logic                 core_default_select_pin,
	input  wire logic                 core_below_target,
	output cdv_pkg::cdv_mode_t        conv_mode,
	output logic [4:0]                core_converter_code,
	output logic [10:0]               core_converter_mv,
	output logic [2:0]                linear_regulator_a_code,
	output logic [2:0]                linear_regulator_b_code,
	output logic                      core_power_good_flag_n,
	output logic                      dvs_busy
);
	import cdv_pkg::*;

	// Reset words as named constants, since a bare literal cannot be bit-selected
	localparam logic [7:0] RST_CTRL2 = `CDV_RST_CTRL2;
	localparam logic [7:0] RST_LDO   = `CDV_RST_LDO;

	// Address match, used by every write and read select
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction

	// Code to millivolts for the core converter
	function automatic logic [10:0] code_to_mv(input logic [4:0] code);
		logic [10:0] mv;
		mv = `CDV_VBASE_MV + 11'(code) * `CDV_VSTEP_MV;
		if (code == `CDV_CODE_TOP) begin
			mv = `CDV_VTOP_MV;
		end
		return mv;
	endfunction

	// Register storage
	logic [3:0]      mode_bits;
	logic            go;
	logic            pin_select;
	logic [2:0]      discharge;
	logic [4:0]      core_target;
	logic [2:0]      slew;
	logic [2:0]      ldo_a;
	logic [2:0]      ldo_b;
	logic [4:0]      stepped_code;
	cdv_dvs_state_t  state;
	cdv_dvs_state_t  next_state;
	logic            step_tick;

	// Write strobes
	wire wr_mode  = reg_req.wr && hit(reg_req.addr, `CDV_OFS_MODE);
	wire wr_ctrl2 = reg_req.wr && hit(reg_req.addr, `CDV_OFS_CTRL2);
	wire wr_core  = reg_req.wr && hit(reg_req.addr, `CDV_OFS_CORE);
	wire wr_slew  = reg_req.wr && hit(reg_req.addr, `CDV_OFS_SLEW);
	wire wr_ldo   = reg_req.wr && hit(reg_req.addr, `CDV_OFS_LDO);

	// Core default follows the select pin
	// pin picks default
	wire [4:0] core_default = core_default_select_pin ? `CDV_RST_CORE_HI : `CDV_RST_CORE_LO;

	wire core_reset_evt = undervoltage_lockout
		| (~conv_enabled[`CDV_BIT_SYS] & ~conv_enabled[`CDV_BIT_CORE])
		| ~warm_reset_input_n
		| power_on_reset_active
		| backup_rail_low;

	// Ramp bookkeeping
	wire ramping     = (state == DVS_RAMP);
	wire at_target   = (stepped_code == core_target);
	wire ramp_done   = ramping && at_target;
	wire immediate   = (slew == `CDV_SLEW_IMMEDIATE);
	wire step_up     = stepped_code < core_target;

	// A fresh go write wins over a same-cycle completion, so the request is not lost
	// go starts ramp
	wire next_go = undervoltage_lockout ? 1'b0
		: wr_ctrl2 ? reg_req.wdata[`CDV_BIT_GO]
		: ramp_done ? 1'b0
		: go;

	// Next stepped code: hold, one step, or jump
	// one code per tick
	logic [4:0] next_stepped;
	always_comb begin
		next_stepped = stepped_code;
		if (core_reset_evt) begin
			next_stepped = core_default;
		end else if (ramping && !at_target) begin
			if (immediate) begin
				next_stepped = core_target;
			end else if (step_tick) begin
				next_stepped = step_up ? stepped_code + 5'h1 : stepped_code - 5'h1;
			end
		end
	end

	// Ramp state machine
	always_comb begin
		next_state = state;
		case (state)
			DVS_IDLE: begin
				if (go && !undervoltage_lockout) begin
					next_state = DVS_RAMP;
				end
			end
			DVS_RAMP: begin
				if (undervoltage_lockout || !go || ramp_done) begin
					next_state = DVS_IDLE;
				end
			end
			default: begin
				next_state = DVS_IDLE;
			end
		endcase
	end

	// Interval pacing runs only while ramping
	cdv_step_timer #(
		.SLOWEST_STEP_CYCLES (SLOWEST_STEP_CYCLES)
	) u_timer (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.run       (ramping && !at_target),
		.slew_code (slew),
		.tick      (step_tick)
	);

	// Converter mode register, low four bits only
	// ripple select
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mode_bits <= `CDV_RST_MODE;
		end else if (undervoltage_lockout) begin
			mode_bits <= `CDV_RST_MODE;
		end else if (wr_mode) begin
			mode_bits <= reg_req.wdata[3:0];
		end
	end

	// Second control register
	// loads 40h
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pin_select <= RST_CTRL2[`CDV_BIT_PINSEL];
			discharge  <= RST_CTRL2[2:0];
		end else if (undervoltage_lockout) begin
			pin_select <= RST_CTRL2[`CDV_BIT_PINSEL];
			discharge  <= RST_CTRL2[2:0];
		end else if (wr_ctrl2) begin
			pin_select <= reg_req.wdata[`CDV_BIT_PINSEL];
			discharge  <= reg_req.wdata[2:0];
		end
	end

	// Go bit and ramp state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			go    <= RST_CTRL2[`CDV_BIT_GO];
			state <= DVS_IDLE;
		end else begin
			go    <= next_go;
			state <= next_state;
		end
	end

	// Core target code; async reset takes the low default, pin is caught at the next core reset event
	// reload default
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			core_target <= `CDV_RST_CORE_LO;
		end else if (core_reset_evt) begin
			core_target <= core_default;
		end else if (wr_core) begin
			core_target <= reg_req.wdata[4:0];
		end
	end

	// Stepped code tracks the target during a ramp
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stepped_code <= `CDV_RST_CORE_LO;
		end else begin
			stepped_code <= next_stepped;
		end
	end

	// Slew and regulator registers
	// slew loads 06h
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			slew  <= `CDV_RST_SLEW;
			ldo_a <= RST_LDO[`CDV_LDOA_LSB +: 3];
			ldo_b <= RST_LDO[`CDV_LDOB_LSB +: 3];
		end else if (undervoltage_lockout) begin
			slew  <= `CDV_RST_SLEW;
			ldo_a <= RST_LDO[`CDV_LDOA_LSB +: 3];
			ldo_b <= RST_LDO[`CDV_LDOB_LSB +: 3];
		end else begin
			if (wr_slew) begin
				slew <= reg_req.wdata[2:0];
			end
			if (wr_ldo) begin
				ldo_a <= reg_req.wdata[`CDV_LDOA_LSB +: 3];
				ldo_b <= reg_req.wdata[`CDV_LDOB_LSB +: 3];
			end
		end
	end

	// Read data selection; unmapped offsets read zero
	// unused bits zero
	wire [7:0] rd_mode  = {4'h0, mode_bits};
	wire [7:0] rd_ctrl2 = {go, pin_select, 3'h0, discharge};
	wire [7:0] rd_core  = {3'h0, core_target};
	wire [7:0] rd_slew  = {5'h0, slew};
	wire [7:0] rd_ldo   = {1'b0, ldo_b, 1'b0, ldo_a};
	wire [7:0] rd_mux   = hit(reg_req.addr, `CDV_OFS_MODE)  ? rd_mode
		: hit(reg_req.addr, `CDV_OFS_CTRL2) ? rd_ctrl2
		: hit(reg_req.addr, `CDV_OFS_CORE)  ? rd_core
		: hit(reg_req.addr, `CDV_OFS_SLEW)  ? rd_slew
		: hit(reg_req.addr, `CDV_OFS_LDO)   ? rd_ldo
		: 8'h00;

	// Read data held until the next read
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd) begin
			reg_rdata <= rd_mux;
		end
	end

	// Effective core code: pin default or stepped register code
	// pin select
	wire [4:0] eff_code = pin_select ? core_default : stepped_code;

	// Power-good flag masked while disabled or ramping; busy is go or ramp
	// flag forced zero
	wire pg_flag = conv_enabled[`CDV_BIT_CORE] & ~go & ~ramping & core_below_target;

	// Outputs toward the analog side, all registered
	// discharge when disabled
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			conv_mode               <= '0;
			core_converter_code     <= `CDV_RST_CORE_LO;
			core_converter_mv       <= `CDV_RST_MV_LO; // Matches the 14h reset code
			linear_regulator_a_code <= RST_LDO[`CDV_LDOA_LSB +: 3];
			linear_regulator_b_code <= RST_LDO[`CDV_LDOB_LSB +: 3];
			core_power_good_flag_n  <= 1'b0;
			dvs_busy                <= 1'b0;
		end else begin
			conv_mode.low_ripple             <= mode_bits[`CDV_BIT_RIPPLE];
			conv_mode.forced_fixed_frequency <= mode_bits[2:0];
			conv_mode.discharge_on           <= discharge & ~conv_enabled;
			core_converter_code              <= eff_code;
			core_converter_mv                <= code_to_mv(eff_code);
			linear_regulator_a_code          <= ldo_a;
			linear_regulator_b_code          <= ldo_b;
			core_power_good_flag_n           <= pg_flag;
			dvs_busy                         <= go | ramping;
		end
	end

endmodule

// ==== tb/cdv_core_ctrl_assertions.sv ====
// Purpose: Port-level checks of the core DVS control block
// Assumes: One sys_clk domain, rstn asynchronous active low
// Notes:   Bound to cdv_core_ctrl at the foot of this file
`timescale 1ns/1ps
module cdv_core_ctrl_assertions #(
	parameter int unsigned SLOWEST_STEP_CYCLES = 3333
) (
	input wire logic                  sys_clk,
	input wire logic                  rstn,
	input wire cdv_pkg::cdv_reg_req_t reg_req,
	input wire logic [7:0]            reg_rdata,
	input wire logic                  undervoltage_lockout,
	input wire logic                  warm_reset_input_n,
	input wire logic                  power_on_reset_active,
	input wire logic                  backup_rail_low,
	input wire logic [2:0]            conv_enabled,
	input wire cdv_pkg::cdv_mode_t    conv_mode,
	input wire logic [4:0]            core_converter_code,
	input wire logic [10:0]           core_converter_mv,
	input wire logic [2:0]            linear_regulator_a_code,
	input wire logic [2:0]            linear_regulator_b_code,
	input wire logic                  core_power_good_flag_n,
	input wire logic                  dvs_busy
);
	import cdv_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// Go write with no core reset event pending
	sequence go_write;
		reg_req.wr && reg_req.addr == 8'h05 && reg_req.wdata[7] && !undervoltage_lockout
			&& warm_reset_input_n && !power_on_reset_active && !backup_rail_low
			&& (|conv_enabled[1:0]);
	endsequence
	sequence undervoltage_lockout_held;
		undervoltage_lockout [*3];
	endsequence
	sequence quiet_ldo;
		(!reg_req.wr && !undervoltage_lockout) [*3];
	endsequence

	// Output relations; flag lags its inputs by one register
	chk_go_starts: assert property (go_write |=> ##1 dvs_busy)
		else $error("ramp did not start after go");
	chk_undervoltage_lockout_idle: assert property (undervoltage_lockout_held |=> !dvs_busy)
		else $error("lockout left ramp running");
	chk_discharge_off: assert property ($stable(conv_enabled) |->
		(conv_mode.discharge_on & conv_enabled) == 3'h0)
		else $error("discharge on an enabled converter");
	chk_undervoltage_lockout_defaults: assert property (undervoltage_lockout_held |=> linear_regulator_a_code == 3'h3
		&& linear_regulator_b_code == 3'h2 && conv_mode == '0)
		else $error("lockout defaults wrong");
	chk_mv_map: assert property (core_converter_mv == ((core_converter_code == 5'h1f) ?
		11'h640 : 11'h320 + 11'h019 * core_converter_code))
		else $error("millivolt map wrong");
	chk_ldo_hold: assert property (quiet_ldo |=> $stable(linear_regulator_a_code)
		&& $stable(linear_regulator_b_code))
		else $error("regulator code moved without write");
	chk_pgood_off: assert property (!conv_enabled[0] |=> !core_power_good_flag_n)
		else $error("power-good set while core off");
	chk_pgood_busy: assert property (dvs_busy |-> !core_power_good_flag_n)
		else $error("power-good set during ramp");
	chk_unmapped_zero: assert property (reg_req.rd && reg_req.addr == 8'h20
		|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule

bind cdv_core_ctrl cdv_core_ctrl_assertions #(
	.SLOWEST_STEP_CYCLES(SLOWEST_STEP_CYCLES)
) cdv_core_ctrl_assertions_inst (
	.sys_clk(sys_clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.undervoltage_lockout(undervoltage_lockout), .warm_reset_input_n(warm_reset_input_n),
	.power_on_reset_active(power_on_reset_active), .backup_rail_low(backup_rail_low),
	.conv_enabled(conv_enabled), .conv_mode(conv_mode),
	.core_converter_code(core_converter_code), .core_converter_mv(core_converter_mv),
	.linear_regulator_a_code(linear_regulator_a_code),
	.linear_regulator_b_code(linear_regulator_b_code),
	.core_power_good_flag_n(core_power_good_flag_n), .dvs_busy(dvs_busy)
);

// ==== tb/cdv_host_model.sv ====
// Purpose: Host side of the register port, one access per task call
// Assumes: Requests change 1 ns after the rising edge
// Notes:   Idle address and data are flipped so stale values never look valid
`timescale 1ns/1ps
module cdv_host_model (
	input  wire logic              sys_clk,
	output cdv_pkg::cdv_reg_req_t reg_req,
	input  wire logic [7:0]        reg_rdata
);
	import cdv_pkg::*;
	initial begin
		reg_req = '0;
	end

	// Strobe for one edge, then release the port
	task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge sys_clk);
		#1;
		reg_req = '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge sys_clk);
		#1;
		reg_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		access(a, d, 1'b1);
	endtask
	// Read data stands until the next read, so taking it 1 ns late is safe
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		access(a, 8'h00, 1'b0);
		d = reg_rdata;
	endtask
endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench of the core DVS control block
// Assumes: Short step count of 128 cycles at the slowest rate
// Notes:   One task per scenario; inputs change 1 ns after the edge
`timescale 1ns/1ps
module tb;
	import cdv_pkg::*;
	localparam int unsigned STEP = 128;
	logic         sys_clk = 1'b0;
	logic         rstn = 1'b0;
	cdv_reg_req_t reg_req;
	logic [7:0]   reg_rdata;
	logic         undervoltage_lockout = 1'b0;
	logic         warm_reset_input_n = 1'b1;
	logic         power_on_reset_active = 1'b0;
	logic         backup_rail_low = 1'b0;
	logic [2:0]   conv_enabled = 3'h7;
	logic         core_default_select_pin = 1'b0;
	logic         core_below_target = 1'b1;
	cdv_mode_t    conv_mode;
	logic [4:0]   core_converter_code;
	logic [10:0]  core_converter_mv;
	logic [2:0]   linear_regulator_a_code;
	logic [2:0]   linear_regulator_b_code;
	logic         core_power_good_flag_n;
	logic         dvs_busy;
	logic [7:0]   rv;
	int           err_total = 0;
	int           total_checks = 0;

	always #25 sys_clk = ~sys_clk;

	cdv_core_ctrl #(.SLOWEST_STEP_CYCLES(STEP)) cdv_core_ctrl_inst (
		.sys_clk(sys_clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.undervoltage_lockout(undervoltage_lockout), .warm_reset_input_n(warm_reset_input_n),
		.power_on_reset_active(power_on_reset_active), .backup_rail_low(backup_rail_low),
		.conv_enabled(conv_enabled), .core_default_select_pin(core_default_select_pin),
		.core_below_target(core_below_target), .conv_mode(conv_mode),
		.core_converter_code(core_converter_code), .core_converter_mv(core_converter_mv),
		.linear_regulator_a_code(linear_regulator_a_code),
		.linear_regulator_b_code(linear_regulator_b_code),
		.core_power_good_flag_n(core_power_good_flag_n), .dvs_busy(dvs_busy));
	cdv_host_model cdv_host_model_inst (.sys_clk(sys_clk), .reg_req(reg_req),
		.reg_rdata(reg_rdata));

	task automatic check(input logic [10:0] seen, input logic [10:0] exp, input string w);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, w, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cdv_host_model_inst.write(a, d);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string w);
		cdv_host_model_inst.read(a, rv);
		check({3'h0, rv}, {3'h0, e}, w);
	endtask
	// Bounded wait for the ramp to finish; a hang ends the run
	task automatic wait_idle(output int n);
		cyc(2);
		n = 2;
		while (dvs_busy !== 1'b0) begin
			cyc(1);
			n++;
			if (n > 5000) begin
				err_total++;
				$display("unexpected at %0t: ramp never ended", $time);
				wrap_up();
			end
		end
	endtask
	task automatic undervoltage_lockout_pulse();
		undervoltage_lockout = 1'b1;
		cyc(3);
		undervoltage_lockout = 1'b0;
		cyc(1);
	endtask
	task automatic go_to(input logic [4:0] t, output int n);
		wr(8'h06, {3'h0, t});
		wr(8'h05, 8'h80);
		wait_idle(n);
		check({6'h0, core_converter_code}, {6'h0, t}, "core code");
		check(core_converter_mv, t == 5'h1f ? 11'h640 : 11'h320 + 11'h019 * t, "mv");
		rchk(8'h05, 8'h00, "go cleared");
	endtask

	// Defaults after lockout with the pin low, then high
	task automatic t_defaults();
		logic [7:0] exp[5] = '{8'h00, 8'h40, 8'h14, 8'h06, 8'h23};
		undervoltage_lockout_pulse();
		for (int i = 0; i < 5; i++) begin
			rchk(8'(4 + i), exp[i], "default");
		end
		check({5'h0, linear_regulator_b_code, linear_regulator_a_code}, 11'h013, "ldo");
		check(core_converter_mv, 11'h514, "pin low mv");
		core_default_select_pin = 1'b1;
		undervoltage_lockout_pulse();
		rchk(8'h06, 8'h1e, "pin high code");
		check(core_converter_mv, 11'h60e, "pin high mv");
		core_default_select_pin = 1'b0;
		$display("test defaults done");
	endtask
	// Each mode bit alone, then unimplemented bits dropped
	task automatic t_mode();
		for (int i = 0; i < 4; i++) begin
			wr(8'h04, 8'(1 << i));
			cyc(2);
			check({7'h0, conv_mode.low_ripple, conv_mode.forced_fixed_frequency},
				11'(1 << i), "mode");
		end
		wr(8'h04, 8'hff);
		rchk(8'h04, 8'h0f, "mode mask");
		check({10'h0, conv_mode.low_ripple}, 11'h1, "ripple");
		$display("test mode done");
	endtask
	// Two-step ramps at every slew code, then the code ends
	task automatic t_ramp();
		int n;
		int k;
		wr(8'h05, 8'h00);
		wr(8'h07, 8'h07);
		go_to(5'h04, n);
		for (int s = 0; s < 8; s++) begin
			wr(8'h07, 8'(s));
			go_to(5'(6 + 2 * s), n);
			k = 2 * (STEP >> s);
			check({10'h0, s == 7 ? n <= 6 : n >= k && n <= k + 12}, 11'h1, "time");
		end
		go_to(5'h1f, n);
		go_to(5'h00, n);
		$display("test ramp done");
	endtask
	// Discharge only while a converter is off
	task automatic t_discharge();
		wr(8'h05, 8'h07);
		conv_enabled = 3'h2;
		cyc(2);
		check({8'h0, conv_mode.discharge_on}, 11'h005, "discharge off");
		check({10'h0, core_power_good_flag_n}, 11'h0, "pgood core off");
		conv_enabled = 3'h7;
		cyc(2);
		check({8'h0, conv_mode.discharge_on}, 11'h000, "discharge on");
		check({10'h0, core_power_good_flag_n}, 11'h1, "pgood below");
		core_below_target = 1'b0;
		cyc(2);
		check({10'h0, core_power_good_flag_n}, 11'h0, "pgood in range");
		core_below_target = 1'b1;
		$display("test discharge done");
	endtask
	// Each core reset event other than lockout brings back the default code
	task automatic t_events();
		for (int e = 0; e < 4; e++) begin
			wr(8'h06, 8'h05);
			warm_reset_input_n = (e != 0);
			power_on_reset_active = (e == 1);
			backup_rail_low = (e == 2);
			conv_enabled = (e == 3) ? 3'h4 : 3'h7;
			cyc(2);
			warm_reset_input_n = 1'b1;
			power_on_reset_active = 1'b0;
			backup_rail_low = 1'b0;
			conv_enabled = 3'h7;
			rchk(8'h06, 8'h14, "event default");
		end
		$display("test events done");
	endtask
	// Regulator fields, unmapped offset, lockout during a slow ramp
	task automatic t_misc();
		wr(8'h08, 8'hff);
		rchk(8'h08, 8'h77, "ldo mask");
		check({5'h0, linear_regulator_b_code, linear_regulator_a_code}, 11'h03f, "ldo");
		wr(8'h20, 8'hff);
		rchk(8'h20, 8'h00, "unmapped");
		wr(8'h07, 8'h00);
		wr(8'h06, 8'h1f);
		wr(8'h05, 8'h80);
		cyc(20);
		check({9'h0, dvs_busy, core_power_good_flag_n}, 11'h2, "pgood in ramp");
		undervoltage_lockout_pulse();
		cyc(3);
		check({10'h0, dvs_busy}, 11'h0, "busy after lockout");
		rchk(8'h05, 8'h40, "go after lockout");
		rchk(8'h07, 8'h06, "slew default");
		$display("test misc done");
	endtask

	initial begin
		cyc(6);
		rstn = 1'b1;
		cyc(1);
		t_defaults();
		t_mode();
		t_ramp();
		t_discharge();
		t_events();
		t_misc();
		wrap_up();
	end
endmodule
